// *** common/cpuix_defs.svh ***
// Constants for the instruction execution block
`ifndef CPUIX_DEFS_SVH
`define CPUIX_DEFS_SVH
`define CPUIX_OP_BITCLR 4'h9
`define CPUIX_OP_BRNEG 8'hE6
`define CPUIX_OP_COMPLEMENT_FILE 6'h07
`define CPUIX_OP_COMPARE_SKIP_EQUAL 7'h31
`define CPUIX_OP_SUBB 6'h15
`define CPUIX_OP_SLEEP 16'h0003
`define CPUIX_OP_CALL 7'h76
`define CPUIX_OP_RETURN 15'h0009
`define CPUIX_OP_TBLRD 14'h0002
`define CPUIX_OP_TBLWR 14'h0003
`define CPUIX_FLG_C 0
`define CPUIX_FLG_DC 1
`define CPUIX_FLG_Z 2
`define CPUIX_FLG_OV 3
`define CPUIX_FLG_N 4
`define CPUIX_ACCESS_BANK 4'h0
`define CPUIX_PC_RESET 21'h000000
`define CPUIX_TP_RESET 21'h000000
`define CPUIX_STATUS_RESET 5'h00
`endif

// *** common/cpuix_pkg.sv ***
// Types for the instruction execution block
package cpuix_pkg;
  typedef enum logic [3:0] {
    CPUIX_Q1 = 4'h1,
    CPUIX_Q2 = 4'h2,
    CPUIX_Q3 = 4'h4,
    CPUIX_Q4 = 4'h8
  } cpuix_phase_t;
  typedef enum logic [1:0] {
    CPUIX_TB_NONE = 2'h0,
    CPUIX_TB_POSTINC = 2'h1,
    CPUIX_TB_POSTDEC = 2'h2,
    CPUIX_TB_PREINC = 2'h3
  } cpuix_tbmode_t;
endpackage : cpuix_pkg

// *** rtl/cpuix_exec.sv ***
// Instruction decoder and executor for a subset of an 8-bit core
// Contract
// - Access bit 0 selects fixed access bank; 1 takes bank from bank select register.
// - Destination bit 0 writes working register; 1 writes addressed file register.
// - File operand comes from 8-bit address field, 0x00 to 0xFF in bank.
// - 21-bit table pointer; modes none, post-inc, post-dec, pre-inc.
// - Fast bit 1 saves or restores via shadow registers; 0 leaves shadows alone.
// - Five ALU flags kept; each instruction updates only its own flags.
// - Bit clear clears chosen file bit in one cycle, no flags changed.
// - Branch if negative loads PC plus two plus twice offset when N set.
// - Branch offset is signed -128..127 words, doubled before adding.
// - Taken branch takes two cycles with a nop; not taken takes one.
// - Complement writes inverse of file to destination; updates N and Z only.
// - Compare unsigned file with working register, no flags, skip next if equal.
// - Sleep clears watchdog and postscaler, sets expired flag, clears powerdown, stops.
// - Subtract with borrow: W minus f minus not carry, to destination, flags NOVCDCZ.
`timescale 1ns/10ps
`default_nettype none
`include "cpuix_defs.svh"
module cpuix_exec (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic [7:0] FILE_RDATA,
  input wire logic WAKE,
  output logic [11:0] FILE_ADDR,
  output logic FILE_WE,
  output logic [7:0] FILE_WDATA,
  output logic [20:0] PC,
  output logic [7:0] WORKING_REGISTER,
  output logic [3:0] BANK_SEL,
  output logic [4:0] STATUS,
  output logic [20:0] TABLE_PTR,
  output logic [20:0] TABLE_ADDR,
  output logic TABLE_STROBE,
  output logic TABLE_WRITE,
  output logic WDT_CLEAR,
  output logic WDT_EXPIRED_FLAG,
  output logic POWERDOWN_FLAG,
  output logic SLEEPING,
  output logic [3:0] PHASE,
  output logic BUSY
);
  cpuix_pkg::cpuix_phase_t phase_reg;
  logic [20:0] pc_reg;
  logic [7:0] w_reg;
  logic [3:0] bsr_reg;
  logic [4:0] status_reg;
  logic [20:0] tp_reg;
  logic [7:0] w_shadow_reg;
  logic [4:0] status_shadow_reg;
  logic [3:0] bsr_shadow_reg;
  logic [1:0] nop_cnt_reg;
  logic skip_two_reg;
  logic sleep_reg;
  logic to_reg;
  logic pd_reg;
  logic wdt_clr_reg;
  logic [15:0] ir_reg;
  logic [7:0] opnd_reg;
  logic [7:0] res_reg;
  logic [4:0] res_flags_reg;
  logic [20:0] tbl_addr_reg;
  logic tbl_stb_reg;
  logic tbl_wr_reg;
  logic is_bcf, is_bn, is_complement_file, is_cpf, is_subb, is_sleep, is_tbl, is_call, is_ret;
  logic [20:0] br_target;
  logic [8:0] sub_full;
  logic [4:0] sub_low;
  logic [7:0] sub_res;
  logic sub_ov;
  logic two_word_next;
  // Decode from the latched instruction word
  assign is_bcf = ir_reg[15:12] == `CPUIX_OP_BITCLR;
  assign is_bn = ir_reg[15:8] == `CPUIX_OP_BRNEG;
  assign is_complement_file = ir_reg[15:10] == `CPUIX_OP_COMPLEMENT_FILE;
  assign is_cpf = ir_reg[15:9] == `CPUIX_OP_COMPARE_SKIP_EQUAL;
  assign is_subb = ir_reg[15:10] == `CPUIX_OP_SUBB;
  assign is_sleep = ir_reg == `CPUIX_OP_SLEEP;
  assign is_tbl = ir_reg[15:2] == `CPUIX_OP_TBLRD || ir_reg[15:2] == `CPUIX_OP_TBLWR;
  assign is_call = ir_reg[15:9] == `CPUIX_OP_CALL;
  assign is_ret = ir_reg[15:1] == `CPUIX_OP_RETURN;
  // Words with the 0xC prefix or 0xEC to 0xEF (call/goto/lfsr) are followed by a second word
  assign two_word_next = INSTR[15:12] == 4'hC || INSTR[15:9] == 7'h76 || INSTR[15:8] == 8'hEF
    || INSTR[15:8] == 8'hEE;
  assign br_target = pc_reg + 21'h000002 + {{12{ir_reg[7]}}, ir_reg[7:0], 1'b0};
  assign sub_full = {1'b0, w_reg} - {1'b0, opnd_reg} - {8'h00, ~status_reg[`CPUIX_FLG_C]};
  assign sub_low = {1'b0, w_reg[3:0]} - {1'b0, opnd_reg[3:0]} - {4'h0, ~status_reg[`CPUIX_FLG_C]};
  assign sub_res = sub_full[7:0];
  assign sub_ov = (w_reg[7] ^ opnd_reg[7]) & (w_reg[7] ^ sub_res[7]);
  assign BUSY = nop_cnt_reg != 2'h0 || phase_reg != cpuix_pkg::CPUIX_Q1 || sleep_reg;
  assign PHASE = phase_reg;
  assign PC = pc_reg;
  assign WORKING_REGISTER = w_reg;
  assign BANK_SEL = bsr_reg;
  assign STATUS = status_reg;
  assign TABLE_PTR = tp_reg;
  assign TABLE_ADDR = tbl_addr_reg;
  assign TABLE_STROBE = tbl_stb_reg;
  assign TABLE_WRITE = tbl_wr_reg;
  assign WDT_CLEAR = wdt_clr_reg;
  assign WDT_EXPIRED_FLAG = to_reg;
  assign POWERDOWN_FLAG = pd_reg;
  assign SLEEPING = sleep_reg;
  // File address: access bank when a is 0, else bank select register
  assign FILE_ADDR = {(ir_reg[8] ? bsr_reg : `CPUIX_ACCESS_BANK), ir_reg[7:0]};
  assign FILE_WE = phase_reg == cpuix_pkg::CPUIX_Q4 && nop_cnt_reg == 2'h0
    && (is_bcf || ((is_complement_file || is_subb) && ir_reg[9]));
  assign FILE_WDATA = res_reg;
  // Four phases per instruction cycle; held while sleeping
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      phase_reg <= cpuix_pkg::CPUIX_Q1;
    end else if (!sleep_reg && (phase_reg != cpuix_pkg::CPUIX_Q1 || INSTR_VALID || nop_cnt_reg != 2'h0)) begin
      unique case (phase_reg)
        cpuix_pkg::CPUIX_Q1: phase_reg <= cpuix_pkg::CPUIX_Q2;
        cpuix_pkg::CPUIX_Q2: phase_reg <= cpuix_pkg::CPUIX_Q3;
        cpuix_pkg::CPUIX_Q3: phase_reg <= cpuix_pkg::CPUIX_Q4;
        cpuix_pkg::CPUIX_Q4: phase_reg <= cpuix_pkg::CPUIX_Q1;
        default: phase_reg <= cpuix_pkg::CPUIX_Q1;
      endcase
    end
  end
  // Q1: latch instruction (decode); Q2: read operand
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      ir_reg <= 16'h0000;
      opnd_reg <= 8'h00;
    end else if (phase_reg == cpuix_pkg::CPUIX_Q1 && INSTR_VALID && nop_cnt_reg == 2'h0 && !sleep_reg) begin
      ir_reg <= INSTR;
    end else if (phase_reg == cpuix_pkg::CPUIX_Q2) begin
      opnd_reg <= FILE_RDATA;
    end
  end
  // Q3: process data
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      res_reg <= 8'h00;
      res_flags_reg <= `CPUIX_STATUS_RESET;
    end else if (phase_reg == cpuix_pkg::CPUIX_Q3) begin
      res_flags_reg <= status_reg;
      if (is_bcf) begin
        res_reg <= opnd_reg & ~(8'h01 << ir_reg[11:9]);
      end else if (is_complement_file) begin
        res_reg <= ~opnd_reg;
        res_flags_reg[`CPUIX_FLG_N] <= ~opnd_reg[7];
        res_flags_reg[`CPUIX_FLG_Z] <= opnd_reg == 8'hFF;
      end else if (is_subb) begin
        res_reg <= sub_res;
        res_flags_reg[`CPUIX_FLG_C] <= ~sub_full[8];
        res_flags_reg[`CPUIX_FLG_DC] <= ~sub_low[4];
        res_flags_reg[`CPUIX_FLG_Z] <= sub_res == 8'h00;
        res_flags_reg[`CPUIX_FLG_N] <= sub_res[7];
        res_flags_reg[`CPUIX_FLG_OV] <= sub_ov;
      end
    end
  end
  // Q4: working register, flags, shadows
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      w_reg <= 8'h00;
      status_reg <= `CPUIX_STATUS_RESET;
      bsr_reg <= 4'h0;
      w_shadow_reg <= 8'h00;
      status_shadow_reg <= `CPUIX_STATUS_RESET;
      bsr_shadow_reg <= 4'h0;
    end else if (phase_reg == cpuix_pkg::CPUIX_Q4 && nop_cnt_reg == 2'h0) begin
      if ((is_complement_file || is_subb) && !ir_reg[9]) begin
        w_reg <= res_reg;
      end
      if (is_complement_file || is_subb) begin
        status_reg <= res_flags_reg;
      end
      if (is_call && ir_reg[8]) begin
        w_shadow_reg <= w_reg;
        status_shadow_reg <= status_reg;
        bsr_shadow_reg <= bsr_reg;
      end else if (is_ret && ir_reg[0]) begin
        w_reg <= w_shadow_reg;
        status_reg <= status_shadow_reg;
        bsr_reg <= bsr_shadow_reg;
      end
    end
  end
  // Program counter and inserted no-operation cycles
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      pc_reg <= `CPUIX_PC_RESET;
      nop_cnt_reg <= 2'h0;
      skip_two_reg <= 1'b0;
    end else if (phase_reg == cpuix_pkg::CPUIX_Q3) begin
      // The word fetched after a compare stands on INSTR by its Q3
      skip_two_reg <= two_word_next;
    end else if (phase_reg == cpuix_pkg::CPUIX_Q4) begin
      if (nop_cnt_reg != 2'h0) begin
        nop_cnt_reg <= nop_cnt_reg - 2'h1;
        // A taken branch already holds its target; only a skip steps past words
        if (!is_bn) begin
          pc_reg <= pc_reg + 21'h000002;
        end
      end else if (is_bn && status_reg[`CPUIX_FLG_N]) begin
        pc_reg <= br_target;
        nop_cnt_reg <= 2'h1;
      end else if (is_cpf && opnd_reg == w_reg) begin
        pc_reg <= pc_reg + 21'h000002;
        nop_cnt_reg <= skip_two_reg ? 2'h2 : 2'h1;
      end else begin
        pc_reg <= pc_reg + 21'h000002;
      end
    end
  end
  // Table pointer modes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      tp_reg <= `CPUIX_TP_RESET;
      tbl_addr_reg <= 21'h000000;
      tbl_stb_reg <= 1'b0;
      tbl_wr_reg <= 1'b0;
    end else begin
      tbl_stb_reg <= 1'b0;
      if (phase_reg == cpuix_pkg::CPUIX_Q4 && nop_cnt_reg == 2'h0 && is_tbl) begin
        tbl_stb_reg <= 1'b1;
        tbl_wr_reg <= ir_reg[2];
        unique case (cpuix_pkg::cpuix_tbmode_t'(ir_reg[1:0]))
          cpuix_pkg::CPUIX_TB_NONE: tbl_addr_reg <= tp_reg;
          cpuix_pkg::CPUIX_TB_POSTINC: begin
            tbl_addr_reg <= tp_reg;
            tp_reg <= tp_reg + 21'h000001;
          end
          cpuix_pkg::CPUIX_TB_POSTDEC: begin
            tbl_addr_reg <= tp_reg;
            tp_reg <= tp_reg - 21'h000001;
          end
          cpuix_pkg::CPUIX_TB_PREINC: begin
            tbl_addr_reg <= tp_reg + 21'h000001;
            tp_reg <= tp_reg + 21'h000001;
          end
        endcase
      end
    end
  end
  // Sleep entry in the last phase; wake input resumes
  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      sleep_reg <= 1'b0;
      to_reg <= 1'b1;
      pd_reg <= 1'b1;
      wdt_clr_reg <= 1'b0;
    end else begin
      wdt_clr_reg <= 1'b0;
      if (sleep_reg && WAKE) begin
        sleep_reg <= 1'b0;
      end else if (phase_reg == cpuix_pkg::CPUIX_Q4 && nop_cnt_reg == 2'h0 && is_sleep) begin
        sleep_reg <= 1'b1;
        wdt_clr_reg <= 1'b1;
        to_reg <= 1'b1;
        pd_reg <= 1'b0;
      end
    end
  end
endmodule : cpuix_exec
`default_nettype wire

// *** sim/cpu_instruction_exec_tb.sv ***
// Self-checking bench for the execution block
`timescale 1ns/10ps
`default_nettype none
`include "cpuix_defs.svh"
module cpu_instruction_exec_tb;
  logic clk, nrst, instr_valid, wake, file_we, sleeping, to_flag, pd_flag, busy, table_write;
  logic [15:0] instr, next_word;
  logic [7:0] file_rdata, file_wdata, working_register;
  logic [11:0] file_addr;
  logic [20:0] pc, table_ptr, pc0, table_addr;
  logic [4:0] status;
  logic [3:0] phase;
  int fail_count = 0;
  int checks_done = 0;
  cpuix_exec uut (.CLK(clk), .NRST(nrst), .INSTR(instr), .INSTR_VALID(instr_valid), .FILE_RDATA(file_rdata),
    .WAKE(wake), .FILE_ADDR(file_addr), .FILE_WE(file_we), .FILE_WDATA(file_wdata), .PC(pc), .WORKING_REGISTER(working_register),
    .BANK_SEL(), .STATUS(status), .TABLE_PTR(table_ptr), .TABLE_ADDR(table_addr), .TABLE_STROBE(),
    .TABLE_WRITE(table_write),
    .WDT_CLEAR(), .WDT_EXPIRED_FLAG(to_flag), .POWERDOWN_FLAG(pd_flag), .SLEEPING(sleeping), .PHASE(phase),
    .BUSY(busy));
  cpuix_filemem u_fm (.clk(clk), .file_addr(file_addr), .file_we(file_we), .file_wdata(file_wdata),
    .file_rdata(file_rdata));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask : chk
  // Offer a word, wait until taken, show the next fetch, then let n instruction cycles pass
  task automatic run(input logic [15:0] w, input int n);
    @(posedge clk);
    instr <= w;
    instr_valid <= 1'b1;
    do @(negedge clk); while (!(phase === 4'h1 && busy === 1'b0));
    @(posedge clk);
    instr_valid <= 1'b0;
    instr <= next_word;
    repeat (4 * n) @(posedge clk);
    @(negedge clk);
  endtask : run
  task automatic summarize();
    if (fail_count == 0 && checks_done > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
  initial begin
    nrst = 1'b0;
    instr = 16'h0000;
    next_word = 16'h0000;
    instr_valid = 1'b0;
    wake = 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(negedge clk);
    chk({to_flag, pd_flag, status}, 7'h60);
    u_fm.mem[12'h012] = 8'hC7;
    u_fm.mem[12'h0FF] = 8'hFF;
    u_fm.mem[12'h021] = 8'hB7;
    u_fm.mem[12'h022] = 8'h03;
    u_fm.mem[12'h030] = 8'h00;
    u_fm.mem[12'h031] = 8'h05;
    u_fm.mem[12'h032] = 8'h02;
    run({4'h9, 3'h7, 1'b0, 8'h12}, 1);
    chk({u_fm.mem[12'h012], status}, {8'h47, 5'h00});
    run({4'h9, 3'h0, 1'b1, 8'hFF}, 1);
    chk(u_fm.mem[12'h0FF], 8'hFE);
    run({6'h07, 2'b00, 8'h12}, 1);
    chk({working_register, u_fm.mem[12'h012], status}, {8'hB8, 8'h47, 5'h10});
    run({6'h07, 2'b10, 8'hFF}, 1);
    chk({working_register, u_fm.mem[12'h0FF], status}, {8'hB8, 8'h01, 5'h00});
    run({6'h15, 2'b00, 8'h21}, 1);
    chk({working_register, status}, {8'h00, 5'h07});
    run({6'h15, 2'b10, 8'h22}, 1);
    chk({working_register, u_fm.mem[12'h022], status}, {8'h00, 8'hFD, 5'h10});
    pc0 = pc;
    run({7'h31, 1'b0, 8'h30}, 2);
    chk({pc, status}, {pc0 + 21'h4, 5'h10});
    pc0 = pc;
    run({7'h31, 1'b0, 8'h31}, 1);
    chk(pc, pc0 + 21'h2);
    pc0 = pc;
    run({8'hE6, 8'h80}, 2);
    chk(pc, 21'(pc0 - 21'hFE));
    run({6'h07, 2'b00, 8'h22}, 1);
    pc0 = pc;
    run({8'hE6, 8'h7F}, 1);
    chk(pc, pc0 + 21'h2);
    for (int m = 0; m < 4; m++) begin
      pc0 = table_ptr;
      run({`CPUIX_OP_TBLRD, m[1:0]}, 1);
      chk(table_ptr, 21'(pc0 + ((m == 2) ? 21'h1FFFFF : {20'h0, m[0]})));
      chk({table_write, table_addr}, {1'b0, (m == 3) ? 21'(pc0 + 21'h1) : pc0});
    end
    run({`CPUIX_OP_TBLWR, 2'h1}, 1);
    chk(table_ptr, 21'h2);
    chk({table_write, table_addr}, {1'b1, 21'h1});
    next_word = 16'hEF00;
    pc0 = pc;
    run({7'h31, 1'b0, 8'h32}, 3);
    chk(pc, pc0 + 21'h6);
    next_word = 16'h0000;
    run(`CPUIX_OP_SLEEP, 1);
    chk({sleeping, to_flag, pd_flag}, 3'b110);
    @(posedge clk);
    wake <= 1'b1;
    for (int i = 0; i < 16 && sleeping !== 1'b0; i++) @(negedge clk);
    chk(sleeping, 1'b0);
    summarize();
  end
endmodule : cpu_instruction_exec_tb
`default_nettype wire

// *** sim/cpuix_exec_chk.sv ***
// Port checker for the execution block
`timescale 1ns/10ps
`default_nettype none
module cpuix_exec_chk (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic [15:0] INSTR,
  input wire logic INSTR_VALID,
  input wire logic WAKE,
  input wire logic FILE_WE,
  input wire logic [20:0] PC,
  input wire logic [4:0] STATUS,
  input wire logic TABLE_STROBE,
  input wire logic WDT_CLEAR,
  input wire logic WDT_EXPIRED_FLAG,
  input wire logic POWERDOWN_FLAG,
  input wire logic SLEEPING,
  input wire logic [3:0] PHASE,
  input wire logic BUSY
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!NRST);
  logic take;
  assign take = PHASE == 4'h1 && INSTR_VALID && !BUSY && !SLEEPING;
  a_phase_onehot: assert property ($onehot(PHASE))
    else $error("phase not one-hot");
  a_phase_order: assert property (PHASE == 4'h2 |=> PHASE == 4'h4)
    else $error("phase order");
  a_we_in_q4: assert property (FILE_WE |-> PHASE == 4'h8)
    else $error("write outside last phase");
  a_pc_at_q4: assert property ($changed(PC) |-> $past(PHASE) == 4'h8)
    else $error("pc moved early");
  a_bcf_flags: assert property (take && INSTR[15:12] == 4'h9 |-> ##2 $stable(STATUS) [*4])
    else $error("bit clear moved flags");
  a_cpf_flags: assert property (take && INSTR[15:9] == 7'h31 |-> ##2 $stable(STATUS) [*4])
    else $error("compare moved flags");
  a_bn_fall: assert property (take && INSTR[15:8] == 8'hE6 && !STATUS[4] |-> ##6 PC == $past(PC, 5) + 21'h2)
    else $error("untaken branch pc");
  a_sleep_flags: assert property ($rose(SLEEPING) |-> WDT_EXPIRED_FLAG && !POWERDOWN_FLAG)
    else $error("sleep flags");
  a_sleep_wdt: assert property ($rose(SLEEPING) |-> WDT_CLEAR)
    else $error("no watchdog clear on sleep");
  a_wdt_pulse: assert property (WDT_CLEAR |=> !WDT_CLEAR)
    else $error("watchdog clear too long");
  a_sleep_holds: assert property (SLEEPING && !WAKE |=> SLEEPING)
    else $error("left sleep unwoken");
  a_tbl_pulse: assert property (TABLE_STROBE |=> !TABLE_STROBE)
    else $error("table strobe too long");
  c_bcf: cover property (take && INSTR[15:12] == 4'h9);
  c_sleep: cover property ($rose(SLEEPING));
  c_tbl: cover property (TABLE_STROBE);
endmodule : cpuix_exec_chk
bind cpuix_exec cpuix_exec_chk u_chk (.CLK(CLK), .NRST(NRST), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
  .WAKE(WAKE), .FILE_WE(FILE_WE), .PC(PC), .STATUS(STATUS), .TABLE_STROBE(TABLE_STROBE), .WDT_CLEAR(WDT_CLEAR),
  .WDT_EXPIRED_FLAG(WDT_EXPIRED_FLAG), .POWERDOWN_FLAG(POWERDOWN_FLAG), .SLEEPING(SLEEPING), .PHASE(PHASE),
  .BUSY(BUSY));
`default_nettype wire

// *** sim/cpuix_filemem.sv ***
// Data register file model
`timescale 1ns/10ps
`default_nettype none
module cpuix_filemem (
  input wire logic clk,
  input wire logic [11:0] file_addr,
  input wire logic file_we,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata
);
  logic [7:0] mem [0:4095];
  assign file_rdata = mem[file_addr];
  always @(posedge clk) begin
    if (file_we)
      mem[file_addr] <= file_wdata;
  end
endmodule : cpuix_filemem
`default_nettype wire
